// ===== rtl/msc_stats.v
// Purpose: Statistics counter bank with round-robin memory sweep and read port
// Assumes: One clock, the counter reference clock; nrst is the global reset
// Notes:   Read answer comes one cycle after the request, from flip-flops
`timescale 1ns/1ps
`include "msc_map.vh"

// Notes on behaviour
// - Bank exists only with management port; counters 32 or 64 bits, default 64.
// - Lower-half read of a 64-bit counter captures its upper half simultaneously.
// - Following upper-half read of that counter returns the captured value.
// - Upper-half read of any other counter answers with an error.
// - Counters are read-only; writes change nothing and answer with an error.
// - Build option chooses whether global reset clears counters; otherwise they keep values.
// - Reading never clears; maximum count wraps to zero on next increment.
// - Decode logic forms the increment bus; counters 4-43 increment only when flagged, counters 0-3 by their accumulated count.
// - Counters 0-3 take internal every-cycle events users cannot see.
// - Increment bus carries one bit per counter, bits 4 to 43.
// - Each level change on an increment bit sets its pending flag; changes before the flag's next visit merge into one increment.
// - Toggles are detected by edge logic on the counter reference clock.
// - Counters live in a shared memory swept round-robin with read-modify-write.
// - Each update takes two memory accesses: a read, then a write-back.
// - Only the requested member of each 7-counter frame-size group is visited; 32 slots.
module msc_stats #(
  parameter MGMT_EN    = 1,
  parameter CNT_WIDE   = 1,
  parameter CLR_ON_RST = 1
) (
  input  wire                                clock,
  input  wire                                nrst,
  input  wire [`MSC_FAST_NUM-1:0]            hf_event,
  input  wire [`MSC_INC_HI:`MSC_INC_LO]      increment_vector,
  input  wire                                mgmt_req,
  input  wire                                mgmt_wr,
  input  wire [`MSC_IDX_W-1:0]               mgmt_idx,
  input  wire                                mgmt_upper,
  output reg                                 mgmt_ack,
  output reg                                 mgmt_err,
  output reg  [`MSC_HALF_W-1:0]              mgmt_rdata
);

  localparam CNT_W = CNT_WIDE ? `MSC_WIDE_W : `MSC_HALF_W;

  generate
    if (MGMT_EN != 0)
    begin : g_bank
      reg  [CNT_W-1:0]                        mem [0:`MSC_NUM_CNT-1];
      wire [`MSC_INC_HI:`MSC_INC_LO]          pend;
      reg  [`MSC_INC_HI:`MSC_INC_LO]          pend_clr;
      wire [`MSC_FAST_NUM*`MSC_ACC_W-1:0]     acc_flat;
      wire [`MSC_NUM_CNT-1:0]                 pend_all;
      reg  [`MSC_SLOT_W-1:0]                  slot;
      reg                                     phase;
      reg  [`MSC_IDX_W-1:0]                   cur_idx;
      reg                                     cur_go;
      reg  [`MSC_ACC_W-1:0]                   cur_delta;
      reg  [CNT_W-1:0]                        cur_val;
      reg  [`MSC_IDX_W-1:0]                   sel_idx;
      reg                                     sel_go;
      reg  [`MSC_ACC_W-1:0]                   sel_delta;
      reg  [`MSC_HALF_W-1:0]                  hold_hi;
      reg  [`MSC_IDX_W-1:0]                   last_idx;
      reg                                     last_ok;
      wire                                    take;
      wire [CNT_W-1:0]                        rd_word;
      wire                                    idx_ok;
      integer                                 k;
      integer                                 g;
      reg  [31:0]                             grp_idx;

      assign pend_all = {pend, {`MSC_FAST_NUM{1'b0}}};
      assign take     = (phase == `MSC_PH_READ) && (slot <= `MSC_FAST_LAST);
      assign idx_ok   = (mgmt_idx <= `MSC_LAST_IDX);
      assign rd_word  = mem[idx_ok ? mgmt_idx : {`MSC_IDX_W{1'b0}}];

      msc_toggle_det u_tog (
        .clock            (clock),
        .nrst             (nrst),
        .increment_vector (increment_vector),
        .pend_clr         (pend_clr),
        .pend             (pend)
      );

      msc_fast_acc u_fast (
        .clock    (clock),
        .nrst     (nrst),
        .hf_event (hf_event),
        .take     (take),
        .take_sel (slot[1:0]),
        .acc_flat (acc_flat)
      );

      // Choose the counter of the current slot and its increment
      always @*
      begin
        sel_idx   = {1'b0, slot};
        sel_go    = 1'b0;
        sel_delta = `MSC_ACC_ONE;
        pend_clr  = {(`MSC_INC_HI-`MSC_INC_LO+1){1'b0}};
        grp_idx   = 32'h0;
        if (slot < `MSC_SLOT_SLOW)
        begin
          sel_delta = acc_flat[slot[1:0]*`MSC_ACC_W +: `MSC_ACC_W];
          sel_go    = (sel_delta != `MSC_ACC_ZERO);
        end
        else if (slot < `MSC_SLOT_RXGRP)
        begin
          sel_go = pend_all[slot];
        end
        else
        begin
          // Frame-size groups are one-hot per frame: visit only the flagged member
          for (g = `MSC_GRP_SIZE-1; g >= 0; g = g - 1)
          begin
            if (slot == `MSC_SLOT_RXGRP && pend_all[`MSC_RX_GRP_BASE+g])
            begin
              grp_idx = `MSC_RX_GRP_BASE + g;
              sel_idx = grp_idx[`MSC_IDX_W-1:0];
              sel_go  = 1'b1;
            end
            if (slot == `MSC_SLOT_TXGRP && pend_all[`MSC_TX_GRP_BASE+g])
            begin
              grp_idx = `MSC_TX_GRP_BASE + g;
              sel_idx = grp_idx[`MSC_IDX_W-1:0];
              sel_go  = 1'b1;
            end
          end
        end
        // Flags are only cleared on the read access of their visit
        if (phase == `MSC_PH_READ && sel_go && sel_idx >= `MSC_INC_LO)
          pend_clr[sel_idx] = 1'b1;
      end

      // Sweep: read access then write-back access per slot
      always @(posedge clock)
      begin
        if (!nrst)
        begin
          slot      <= `MSC_SLOT_FIRST;
          phase     <= `MSC_PH_READ;
          cur_idx   <= {`MSC_IDX_W{1'b0}};
          cur_go    <= 1'b0;
          cur_delta <= `MSC_ACC_ZERO;
          cur_val   <= {CNT_W{1'b0}};
        end
        else if (phase == `MSC_PH_READ)
        begin
          cur_idx   <= sel_idx;
          cur_go    <= sel_go;
          cur_delta <= sel_delta;
          cur_val   <= mem[sel_idx];
          phase     <= `MSC_PH_WRITE;
        end
        else
        begin
          phase <= `MSC_PH_READ;
          // 32 slots serve 44 counters; wraps back to slot 0
          slot  <= (slot == `MSC_SLOT_LAST) ? `MSC_SLOT_FIRST : slot + 1'b1;
        end
      end

      // Counter memory; reset clearing is a build option
      always @(posedge clock)
      begin
        if (!nrst && CLR_ON_RST != 0)
        begin
          for (k = 0; k < `MSC_NUM_CNT; k = k + 1)
            mem[k] <= {CNT_W{1'b0}};
        end
        else if (nrst && phase == `MSC_PH_WRITE && cur_go)
          // Natural overflow of the adder gives the wrap to zero
          mem[cur_idx] <= cur_val + {{(CNT_W-`MSC_ACC_W){1'b0}}, cur_delta};
      end

      // Management access: answer one cycle after the request
      always @(posedge clock)
      begin
        if (!nrst)
        begin
          mgmt_ack   <= 1'b0;
          mgmt_err   <= 1'b0;
          mgmt_rdata <= {`MSC_HALF_W{1'b0}};
          hold_hi    <= {`MSC_HALF_W{1'b0}};
          last_idx   <= {`MSC_IDX_W{1'b0}};
          last_ok    <= 1'b0;
        end
        else
        begin
          mgmt_ack   <= mgmt_req;
          mgmt_err   <= 1'b0;
          mgmt_rdata <= {`MSC_HALF_W{1'b0}};
          if (mgmt_req)
          begin
            if (mgmt_wr || !idx_ok)
              mgmt_err <= 1'b1;
            else if (!mgmt_upper)
            begin
              // Read leaves the count untouched
              mgmt_rdata <= rd_word[`MSC_HALF_W-1:0];
              hold_hi    <= CNT_WIDE ? rd_word[CNT_W-1:CNT_W-`MSC_HALF_W] : {`MSC_HALF_W{1'b0}};
              last_idx   <= mgmt_idx;
              last_ok    <= (CNT_WIDE != 0);
            end
            else if (last_ok && last_idx == mgmt_idx)
              mgmt_rdata <= hold_hi;
            else
              mgmt_err <= 1'b1;
          end
        end
      end
    end
    else
    begin : g_none
      // Without the management port there is no counter bank
      always @(posedge clock)
      begin
        mgmt_ack   <= 1'b0;
        mgmt_err   <= 1'b0;
        mgmt_rdata <= {`MSC_HALF_W{1'b0}};
      end
    end
  endgenerate

endmodule

// ===== rtl/msc_map.vh
// Purpose: Shared constants of the MAC statistics counter bank
// Assumes: Included by every design file of the counter bank
// Notes:   Counter indices, sweep slots and access codes live here
`ifndef MSC_MAP_VH
`define MSC_MAP_VH

`define MSC_NUM_CNT      44
`define MSC_IDX_W        6
`define MSC_LAST_IDX     6'h2b
`define MSC_FAST_NUM     4
`define MSC_FAST_LAST    3
`define MSC_INC_LO       4
`define MSC_INC_HI       43
`define MSC_SLOT_W       5
`define MSC_SLOT_LAST    5'h1f
`define MSC_SLOT_FIRST   5'h00
`define MSC_SLOT_SLOW    5'h04
`define MSC_SLOT_RXGRP   5'h1e
`define MSC_SLOT_TXGRP   5'h1f
`define MSC_RX_GRP_BASE  30
`define MSC_TX_GRP_BASE  37
`define MSC_GRP_SIZE     7
`define MSC_ACC_W        7
`define MSC_ACC_ZERO     7'h00
`define MSC_ACC_ONE      7'h01
`define MSC_HALF_W       32
`define MSC_WIDE_W       64
`define MSC_PH_READ      1'b0
`define MSC_PH_WRITE     1'b1

`endif

// ===== rtl/msc_toggle_det.v
// Purpose: Toggle detection and pending flags for the low-rate increment bus
// Assumes: Increment bits are synchronous to the counter reference clock
// Notes:   A toggle arriving in the cycle its flag is cleared keeps the flag set
`timescale 1ns/1ps
`include "msc_map.vh"

module msc_toggle_det (
  input  wire                                    clock,
  input  wire                                    nrst,
  input  wire [`MSC_INC_HI:`MSC_INC_LO]          increment_vector,
  input  wire [`MSC_INC_HI:`MSC_INC_LO]          pend_clr,
  output reg  [`MSC_INC_HI:`MSC_INC_LO]          pend
);

  reg [`MSC_INC_HI:`MSC_INC_LO] prev;

  genvar i;
  generate
    for (i = `MSC_INC_LO; i <= `MSC_INC_HI; i = i + 1)
    begin : g_bit
      always @(posedge clock)
      begin
        // Reload the level on reset so a high bit is not seen as a toggle
        if (!nrst)
        begin
          prev[i] <= increment_vector[i];
          pend[i] <= 1'b0;
        end
        else
        begin
          prev[i] <= increment_vector[i];
          // Either edge requests one increment; set wins over clear
          pend[i] <= (prev[i] ^ increment_vector[i]) | (pend[i] & ~pend_clr[i]);
        end
      end
    end
  endgenerate

endmodule

// ===== rtl/msc_fast_acc.v
// Purpose: Accumulators for the four high-rate internal event sources
// Assumes: Each event input may be high on every clock cycle
// Notes:   Sweep takes the count once per round; 64 cycles per round fit 7 bits
`timescale 1ns/1ps
`include "msc_map.vh"

module msc_fast_acc (
  input  wire                                     clock,
  input  wire                                     nrst,
  input  wire [`MSC_FAST_NUM-1:0]                 hf_event,
  input  wire                                     take,
  input  wire [1:0]                               take_sel,
  output wire [`MSC_FAST_NUM*`MSC_ACC_W-1:0]      acc_flat
);

  genvar i;
  generate
    for (i = 0; i < `MSC_FAST_NUM; i = i + 1)
    begin : g_acc
      localparam integer   SEL = i;
      reg [`MSC_ACC_W-1:0] acc;
      wire                 hit;

      assign hit = take && (take_sel == SEL[1:0]);
      assign acc_flat[i*`MSC_ACC_W +: `MSC_ACC_W] = acc;

      always @(posedge clock)
      begin
        if (!nrst)
          acc <= `MSC_ACC_ZERO;
        else if (hit)
          // Event in the take cycle starts the next round's count
          acc <= hf_event[i] ? `MSC_ACC_ONE : `MSC_ACC_ZERO;
        else if (hf_event[i])
          acc <= acc + `MSC_ACC_ONE;
      end
    end
  endgenerate

endmodule

// ===== tb/msc_stats_asserts.sv
// Purpose: Port assertions for the statistics counter bank
// Assumes: Management port built in
// Notes:   Tracks the last good lower read to judge upper reads
`timescale 1ns/1ps
`include "msc_map.vh"
module msc_stats_asserts #(
  parameter CNT_WIDE = 1
) (
  input wire                           clock,
  input wire                           nrst,
  input wire [`MSC_FAST_NUM-1:0]       hf_event,
  input wire [`MSC_INC_HI:`MSC_INC_LO] increment_vector,
  input wire                           mgmt_req,
  input wire                           mgmt_wr,
  input wire [`MSC_IDX_W-1:0]          mgmt_idx,
  input wire                           mgmt_upper,
  input wire                           mgmt_ack,
  input wire                           mgmt_err,
  input wire [`MSC_HALF_W-1:0]         mgmt_rdata
);
  reg  [`MSC_IDX_W-1:0] last_idx;
  reg                   last_ok;
  wire                  rd_lo = mgmt_req && !mgmt_wr && !mgmt_upper && mgmt_idx <= `MSC_LAST_IDX;
  wire                  rd_up = mgmt_req && !mgmt_wr && mgmt_upper;
  wire                  up_ok = rd_up && last_ok && mgmt_idx == last_idx && CNT_WIDE != 0;
  // Errored accesses leave the record alone
  always @(posedge clock) last_ok <= nrst && (last_ok || rd_lo);
  always @(posedge clock) last_idx <= rd_lo ? mgmt_idx : last_idx;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  chk_ack_next: assert property (mgmt_req |=> mgmt_ack)
    else $error("no answer after request");
  chk_ack_cause: assert property (mgmt_ack |-> $past(mgmt_req))
    else $error("answer without request");
  chk_quiet_idle: assert property (!mgmt_ack |-> mgmt_rdata == 32'h0 && !mgmt_err)
    else $error("data or error outside answer");
  chk_write_error: assert property (mgmt_req && mgmt_wr |=> mgmt_err && mgmt_rdata == 32'h0)
    else $error("write not refused");
  chk_unmapped_error: assert property (mgmt_req && mgmt_idx > `MSC_LAST_IDX |=> mgmt_err)
    else $error("unmapped index not refused");
  chk_lower_clean: assert property (rd_lo |=> !mgmt_err)
    else $error("lower read refused");
  chk_upper_foreign: assert property (rd_up && !up_ok |=> mgmt_err && mgmt_rdata == 32'h0)
    else $error("foreign upper read not refused");
  chk_upper_ok: assert property (up_ok |=> !mgmt_err)
    else $error("matching upper read refused");
  chk_upper_repeat: assert property (up_ok ##1 up_ok |=> mgmt_rdata == $past(mgmt_rdata))
    else $error("held upper half changed");
endmodule

bind msc_stats msc_stats_asserts #(.CNT_WIDE(CNT_WIDE)) u_chk (.clock(clock), .nrst(nrst),
  .hf_event(hf_event), .increment_vector(increment_vector), .mgmt_req(mgmt_req), .mgmt_wr(mgmt_wr),
  .mgmt_idx(mgmt_idx), .mgmt_upper(mgmt_upper), .mgmt_ack(mgmt_ack), .mgmt_err(mgmt_err),
  .mgmt_rdata(mgmt_rdata));

// ===== tb/msc_evt_src.sv
// Purpose: Event decode stand-in for the increment bus and fast events
// Assumes: Bench flips one level bit per low-rate event
// Notes:   Spacing of events is left to the bench
`timescale 1ns/1ps
`include "msc_map.vh"
module msc_evt_src (
  input  wire                           clock,
  input  wire [`MSC_INC_HI:`MSC_INC_LO] event_lvl,
  input  wire [`MSC_FAST_NUM-1:0]       hf_in,
  output reg  [`MSC_INC_HI:`MSC_INC_LO] increment_vector,
  output reg  [`MSC_FAST_NUM-1:0]       hf_event
);
  // Mixed idle levels so both edge directions start from a real level
  localparam [`MSC_INC_HI:`MSC_INC_LO] IDLE = 40'h5a0f3c96e1;
  // Outputs settle at the first falling edge, well inside reset
  always @(negedge clock)
  begin
    increment_vector <= event_lvl ^ IDLE;
    hf_event         <= hf_in;
  end
endmodule

// ===== tb/msc_stats_tb.sv
// Purpose: Self-checking bench for the statistics counter bank
// Assumes: Default build and a 32-bit build; counts stay far below a wrap
// Notes:   Low-rate events spaced beyond one sweep round so none merge
`timescale 1ns/1ps
`include "msc_map.vh"
module msc_stats_tb;
  reg                            clock;
  reg                            nrst;
  reg  [`MSC_INC_HI:`MSC_INC_LO] tlvl;
  reg  [`MSC_FAST_NUM-1:0]       hf_in;
  wire [`MSC_INC_HI:`MSC_INC_LO] increment_vector;
  wire [`MSC_FAST_NUM-1:0]       hf_event;
  reg                            mgmt_req;
  reg                            mgmt_wr;
  reg  [`MSC_IDX_W-1:0]          mgmt_idx;
  reg                            mgmt_upper;
  wire                           mgmt_ack;
  wire                           mgmt_err;
  wire [`MSC_HALF_W-1:0]         mgmt_rdata;
  wire                           narrow_ack;
  wire                           narrow_err;
  wire [`MSC_HALF_W-1:0]         narrow_rdata;
  reg  [15:0]                    row;
  integer                        num_errors = 0;
  integer                        checks = 0;
  integer                        cycles = 0;
  integer                        i;
  integer                        k;
  // Rows of {index, event count}
  localparam [127:0] TBL = 128'h0005_0307_0402_1d01_1e02_2403_2501_2b02;
  msc_evt_src peer (.clock(clock), .event_lvl(tlvl), .hf_in(hf_in), .increment_vector(increment_vector),
    .hf_event(hf_event));
  msc_stats uut (.clock(clock), .nrst(nrst), .hf_event(hf_event), .increment_vector(increment_vector),
    .mgmt_req(mgmt_req), .mgmt_wr(mgmt_wr), .mgmt_idx(mgmt_idx), .mgmt_upper(mgmt_upper),
    .mgmt_ack(mgmt_ack), .mgmt_err(mgmt_err), .mgmt_rdata(mgmt_rdata));
  // 32-bit build on the same port; every upper-half read must be refused
  msc_stats #(.CNT_WIDE(0)) uut_narrow (.clock(clock), .nrst(nrst), .hf_event(hf_event),
    .increment_vector(increment_vector), .mgmt_req(mgmt_req), .mgmt_wr(mgmt_wr), .mgmt_idx(mgmt_idx),
    .mgmt_upper(mgmt_upper), .mgmt_ack(narrow_ack), .mgmt_err(narrow_err), .mgmt_rdata(narrow_rdata));
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;  // 40 MHz suits a 10/100 link
  end
  task conclude;
  begin
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  always @(posedge clock)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      num_errors = num_errors + 1;
      $display("ERROR %0t ns: timeout", $time);
      conclude;
    end
  end
  task cmp(input [33:0] got, input [33:0] exp);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("ERROR %0t ns: answer %h expected %h", $time, got, exp);
    end
  end
  endtask
  task rd(input [5:0] idx, input up, input wr, input er, input [31:0] dat);
  begin
    @(negedge clock);
    mgmt_req <= 1'b1;
    mgmt_wr <= wr;
    mgmt_idx <= idx;
    mgmt_upper <= up;
    @(negedge clock);
    mgmt_req <= 1'b0;
    cmp({mgmt_ack, mgmt_err, mgmt_rdata}, {1'b1, er, dat});
  end
  endtask
  // Fast events run back to back; low-rate ones keep a frame time apart
  task ev(input [5:0] idx, input [7:0] n);
  begin
    for (k = 0; k < n; k = k + 1)
    begin
      @(negedge clock);
      if (idx < 4)
        hf_in[idx] <= 1'b1;
      else
        tlvl[idx] <= ~tlvl[idx];
      repeat (idx < 4 ? 0 : 68) @(negedge clock);
    end
    @(negedge clock);
    hf_in <= 4'h0;
    repeat (70) @(negedge clock);
  end
  endtask
  initial
  begin
    nrst = 1'b0;
    tlvl = 40'h0;
    hf_in = 4'h0;
    mgmt_req = 1'b0;
    mgmt_wr = 1'b0;
    mgmt_idx = 6'h00;
    mgmt_upper = 1'b0;
    repeat (2) @(negedge clock);
    nrst <= 1'b1;
    rd(6'h04, 1'b1, 1'b0, 1'b1, 32'h0);
    for (i = 0; i < 8; i = i + 1)
    begin
      row = TBL[16*(7-i) +: 16];
      ev(row[13:8], row[7:0]);
      rd(row[13:8], 1'b0, 1'b0, 1'b0, {24'h0, row[7:0]});
      cmp({narrow_ack, narrow_err, narrow_rdata}, {2'b10, 24'h0, row[7:0]});
      rd(row[13:8], 1'b0, 1'b0, 1'b0, {24'h0, row[7:0]});
      rd(row[13:8], 1'b1, 1'b0, 1'b0, 32'h0);
      cmp({narrow_ack, narrow_err, narrow_rdata}, 34'h300000000);
      $display("row %0d done", i);
    end
    rd(6'h04, 1'b0, 1'b1, 1'b1, 32'h0);
    rd(6'h04, 1'b0, 1'b0, 1'b0, 32'h2);
    rd(6'h05, 1'b1, 1'b0, 1'b1, 32'h0);
    rd(6'h2c, 1'b0, 1'b0, 1'b1, 32'h0);
    rd(6'h04, 1'b1, 1'b0, 1'b0, 32'h0);
    @(negedge clock);
    mgmt_req <= 1'b1;
    @(negedge clock);
    cmp({mgmt_ack, mgmt_err, mgmt_rdata}, 34'h200000000);
    @(negedge clock);
    mgmt_req <= 1'b0;
    cmp({mgmt_ack, mgmt_err, mgmt_rdata}, 34'h200000000);
    $display("access tests done");
    nrst <= 1'b0;
    tlvl <= ~tlvl;
    repeat (2) @(negedge clock);
    nrst <= 1'b1;
    repeat (70) @(negedge clock);
    rd(6'h04, 1'b1, 1'b0, 1'b1, 32'h0);
    rd(6'h04, 1'b0, 1'b0, 1'b0, 32'h0);
    rd(6'h2b, 1'b0, 1'b0, 1'b0, 32'h0);
    $display("reset test done");
    conclude;
  end
endmodule
